// ### hw/async_read_defs.svh
// Widths, reset values and counts for the select-strobe read sequencer.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ASYNC_READ_DEFS_SVH
`define ASYNC_READ_DEFS_SVH

// =====================================================================
// Widths
`define REGION_COUNT      4
`define REGION_W          2
`define ADDR_W            13
`define BANK_W            2
`define DATA_W            16
`define BYTE_EN_W         2
`define BEATS_W           3
`define TURN_W            2
`define SETUP_W           4
`define STROBE_W          6
`define HOLD_W            3
`define CNT_W             6

// =====================================================================
// Reset and idle values
`define CS_IDLE           1'b1
`define OE_IDLE           1'b1
`define WE_IDLE           1'b1
`define BE_IDLE           2'h3
`define ADDR_IDLE         13'h0000
`define BANK_IDLE         2'h0
`define DATA_RESET        16'h0000
`define TURN_ONE          2'h1

`endif

// ### hw/async_read_pkg.sv
// Types shared by the select-strobe read sequencer and its testbench.
// Assumes the defs header sits beside it in hw/.
`include "async_read_defs.svh"

package async_read_pkg;

    typedef logic [`REGION_W-1:0] region_idx_t;
    typedef logic [`ADDR_W-1:0]   ext_addr_t;
    typedef logic [`DATA_W-1:0]   ext_data_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TURN,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } seq_state_t;

    typedef enum logic [1:0] {
        LAST_NONE,
        LAST_READ,
        LAST_WRITE
    } last_op_t;

endpackage : async_read_pkg

// ### hw/phase_counter.sv
// Down counter that times the turnaround, setup, strobe and hold phases.
// Assumes the caller loads it on every phase entry with length minus one.
`timescale 1ns/1ps
`include "async_read_defs.svh"

module phase_counter (
    input  wire logic              core_clk_i,  // Interface clock
    input  wire logic              rst_i,       // Sync reset, high
    input  wire logic              load_i,      // Load a new phase length
    input  wire logic [`CNT_W-1:0] load_val_i,  // Phase length minus one
    output logic                   zero_o       // Last cycle of the phase
);

    logic [`CNT_W-1:0] count_q;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            count_q <= '0;
        else if (load_i)
            count_q <= load_val_i;
        else if (count_q != '0)
            count_q <= count_q - `CNT_W'(1);
    end

    assign zero_o = (count_q == '0);

endmodule : phase_counter

// ### hw/async_read_select_strobe.sv
// Read sequencer for an external asynchronous memory, select-strobe capable.
// Assumes an outside arbiter drives top_priority_i and a write engine
// reports finished bus writes on write_done_i, both on core_clk_i.
`timescale 1ns/1ps
`include "async_read_defs.svh"

// Summary of operation
// - Write strobe stays high during reads.
// - Start only when request is top priority.
// - Repeat access cycles until all beats read.
// - Wait programmed turnaround cycles before setup.
// - No turnaround when read follows read.
// - One turnaround after write with zero field.
// - Recheck priority after turnaround, then setup.
// - Lost priority after turnaround abandons read.
// - Load setup, strobe, hold at setup start.
// - Address and bank valid from setup start.
// - Byte enables valid from setup start.
// - Select-strobe: select and enable fall together.
// - Select-strobe: select and enable rise at strobe end; normal mode select rises at final hold end.
// - Select-strobe only when region bit set.
// - Capture read data at strobe end.
// - Release address and enables after final hold.
// - Next beat reenters setup, keeps timings.
module async_read_select_strobe
    import async_read_pkg::*;
(
    input  wire logic                                   core_clk_i,       // Interface clock, 40 MHz
    input  wire logic                                   rst_i,            // Sync reset, high
    input  wire logic                                   req_valid_i,      // Read request pending
    input  wire async_read_pkg::region_idx_t            req_region_i,     // Target region
    input  wire async_read_pkg::ext_addr_t              req_addr_i,       // First beat address
    input  wire logic [`BANK_W-1:0]                     req_bank_i,       // Bank address
    input  wire logic [`BYTE_EN_W-1:0]                  req_byte_en_i,    // Byte enables, high
    input  wire logic [`BEATS_W-1:0]                    req_beats_i,      // Access cycles minus one
    input  wire logic                                   top_priority_i,   // Read is highest priority
    input  wire logic                                   write_done_i,     // Bus write finished, pulse
    input  wire logic [`REGION_COUNT-1:0]               cfg_ss_i,         // Select-strobe per region
    input  wire logic [`REGION_COUNT-1:0][`TURN_W-1:0]  cfg_turn_i,       // Turnaround cycles
    input  wire logic [`REGION_COUNT-1:0][`SETUP_W-1:0] cfg_setup_i,      // Read setup minus one
    input  wire logic [`REGION_COUNT-1:0][`STROBE_W-1:0] cfg_strobe_i,    // Read strobe minus one
    input  wire logic [`REGION_COUNT-1:0][`HOLD_W-1:0]  cfg_hold_i,       // Read hold minus one
    input  wire async_read_pkg::ext_data_t              external_data_i,  // Memory data bus
    output logic [`REGION_COUNT-1:0]                    chip_select_n_o,  // Region selects, low
    output logic                                        output_enable_n_o, // Output enable, low
    output logic                                        write_strobe_n_o, // Write strobe, low
    output async_read_pkg::ext_addr_t                   external_address_o, // Memory address
    output logic [`BANK_W-1:0]                          bank_address_o,   // Bank address
    output logic [`BYTE_EN_W-1:0]                       byte_enable_n_o,  // Byte enables, low
    output logic                                        req_accept_o,     // Request taken, pulse
    output logic                                        req_abort_o,      // Read abandoned, pulse
    output logic                                        busy_o,           // Sequence in progress
    output async_read_pkg::ext_data_t                   rd_data_o,        // Captured beat data
    output logic                                        rd_valid_o,       // Beat data valid, pulse
    output logic                                        rd_last_o,        // Final beat, with valid
    output logic                                        done_o            // Request complete, pulse
);
    import async_read_pkg::*;

    // =================================================================
    // Sequencer state
    seq_state_t            state_q;
    last_op_t              last_op_q;
    region_idx_t           region_q;
    logic                  ss_q;
    ext_addr_t             addr_q;
    logic [`BEATS_W-1:0]   beats_left_q;
    logic [`SETUP_W-1:0]   setup_q;
    logic [`STROBE_W-1:0]  strobe_q;
    logic [`HOLD_W-1:0]    hold_q;
    logic [`BANK_W-1:0]    bank_address_hold_q;
    logic [`BYTE_EN_W-1:0] byte_en_hold_q;
    logic                  cnt_zero;
    logic                  cnt_load;
    logic [`CNT_W-1:0]     cnt_val;
    logic [`TURN_W-1:0]    turn_cnt;
    logic [`TURN_W-1:0]    ta_field;
    logic                  accept;
    logic                  enter_first;
    logic                  enter_again;
    logic                  enter_strobe;
    logic                  leave_strobe;
    logic                  leave_hold;
    logic                  leave_final;
    logic                  ss_now;
    region_idx_t           region_now;
    logic                  cs_assert;
    logic                  cs_release;

    assign accept       = (state_q == ST_IDLE) && req_valid_i && top_priority_i;
    assign ta_field     = cfg_turn_i[req_region_i];
    assign enter_first  = (accept && (turn_cnt == '0)) ||
                          ((state_q == ST_TURN) && cnt_zero && top_priority_i);
    assign enter_again  = (state_q == ST_HOLD) && cnt_zero && (beats_left_q != '0);
    assign enter_strobe = (state_q == ST_SETUP) && cnt_zero;
    assign leave_strobe = (state_q == ST_STROBE) && cnt_zero;
    assign leave_hold   = (state_q == ST_HOLD) && cnt_zero;
    assign leave_final  = leave_hold && (beats_left_q == '0);
    assign ss_now       = (state_q == ST_IDLE) ? cfg_ss_i[req_region_i] : ss_q;
    assign region_now   = (state_q == ST_IDLE) ? req_region_i : region_q;

    // Turnaround length from the previous bus operation
    always_comb
    begin
        if (last_op_q == LAST_READ)
            turn_cnt = '0;
        else if ((last_op_q == LAST_WRITE) && (ta_field == '0))
            turn_cnt = `TURN_ONE;
        else
            turn_cnt = ta_field;
    end

    // =================================================================
    // Phase counter loads
    always_comb
    begin
        cnt_load = 1'b0;
        cnt_val  = '0;
        unique case (state_q)
            ST_IDLE:
            begin
                if (accept && (turn_cnt != '0))
                begin
                    cnt_load = 1'b1;
                    cnt_val  = `CNT_W'(turn_cnt - `TURN_W'(1));
                end
                else if (accept)
                begin
                    cnt_load = 1'b1;
                    cnt_val  = `CNT_W'(cfg_setup_i[req_region_i]);
                end
            end
            ST_TURN:
            begin
                if (enter_first)
                begin
                    cnt_load = 1'b1;
                    cnt_val  = `CNT_W'(cfg_setup_i[region_q]);
                end
            end
            ST_SETUP:
            begin
                cnt_load = enter_strobe;
                cnt_val  = `CNT_W'(strobe_q);
            end
            ST_STROBE:
            begin
                cnt_load = leave_strobe;
                cnt_val  = `CNT_W'(hold_q);
            end
            ST_HOLD:
            begin
                cnt_load = enter_again;
                cnt_val  = `CNT_W'(setup_q);
            end
        endcase
    end

    phase_counter u_phase_counter (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .load_i     (cnt_load),
        .load_val_i (cnt_val),
        .zero_o     (cnt_zero)
    );

    // =================================================================
    // State transitions
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            state_q <= ST_IDLE;
        else
        begin
            unique case (state_q)
                ST_IDLE:   if (accept) state_q <= (turn_cnt == '0) ? ST_SETUP : ST_TURN;
                ST_TURN:   if (cnt_zero) state_q <= top_priority_i ? ST_SETUP : ST_IDLE;
                ST_SETUP:  if (cnt_zero) state_q <= ST_STROBE;
                ST_STROBE: if (cnt_zero) state_q <= ST_HOLD;
                ST_HOLD:   if (cnt_zero) state_q <= (beats_left_q != '0) ? ST_SETUP : ST_IDLE;
            endcase
        end
    end

    // Request context; region and mode held for all beats, address and beat count step per beat
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            region_q     <= '0;
            ss_q         <= 1'b0;
            addr_q       <= `ADDR_IDLE;
            beats_left_q <= '0;
        end
        else if (accept)
        begin
            region_q     <= req_region_i;
            ss_q         <= cfg_ss_i[req_region_i];
            addr_q       <= req_addr_i;
            beats_left_q <= req_beats_i;
        end
        else if (enter_again)
        begin
            addr_q       <= addr_q + `ADDR_W'(1);
            beats_left_q <= beats_left_q - `BEATS_W'(1);
        end
    end

    // Timings latched once per request; later beats reuse them
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            setup_q  <= '0;
            strobe_q <= '0;
            hold_q   <= '0;
        end
        else if (enter_first)
        begin
            setup_q  <= cfg_setup_i[region_now];
            strobe_q <= cfg_strobe_i[region_now];
            hold_q   <= cfg_hold_i[region_now];
        end
    end

    // Bus history for turnaround; a write report outranks a read end
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            last_op_q <= LAST_NONE;
        else if (write_done_i)
            last_op_q <= LAST_WRITE;
        else if (leave_final)
            last_op_q <= LAST_READ;
    end

    // =================================================================
    // Memory pins
    assign cs_assert  = ss_now ? enter_strobe : enter_first;
    assign cs_release = ss_q ? leave_strobe : leave_final;

    genvar g;
    generate
        for (g = 0; g < `REGION_COUNT; g++)
        begin : g_cs
            always_ff @(posedge core_clk_i)
            begin
                if (rst_i)
                    chip_select_n_o[g] <= `CS_IDLE;
                else if (cs_assert && (region_now == region_idx_t'(g)))
                    chip_select_n_o[g] <= 1'b0;
                else if (cs_release)
                    chip_select_n_o[g] <= `CS_IDLE;
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            output_enable_n_o <= `OE_IDLE;
        else if (enter_strobe)
            output_enable_n_o <= 1'b0;
        else if (leave_strobe)
            output_enable_n_o <= `OE_IDLE;
    end

    // Reads never write, so the strobe flop only ever holds idle
    always_ff @(posedge core_clk_i)
    begin
        write_strobe_n_o <= `WE_IDLE;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            external_address_o <= `ADDR_IDLE;
            bank_address_o     <= `BANK_IDLE;
            byte_enable_n_o    <= `BE_IDLE;
        end
        else if (enter_first)
        begin
            external_address_o <= (state_q == ST_IDLE) ? req_addr_i : addr_q;
            bank_address_o     <= (state_q == ST_IDLE) ? req_bank_i : bank_address_hold_q;
            byte_enable_n_o    <= (state_q == ST_IDLE) ? ~req_byte_en_i : ~byte_en_hold_q;
        end
        else if (enter_again)
        begin
            external_address_o <= addr_q + `ADDR_W'(1);
            bank_address_o     <= bank_address_hold_q;
            byte_enable_n_o    <= ~byte_en_hold_q;
        end
        else if (leave_hold)
        begin
            external_address_o <= `ADDR_IDLE;
            bank_address_o     <= `BANK_IDLE;
            byte_enable_n_o    <= `BE_IDLE;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            bank_address_hold_q <= `BANK_IDLE;
            byte_en_hold_q      <= '0;
        end
        else if (accept)
        begin
            bank_address_hold_q <= req_bank_i;
            byte_en_hold_q      <= req_byte_en_i;
        end
    end

    // =================================================================
    // Read data capture
    // The pin flop samples at the strobe-end edge; the second stage only
    // resynchronises, so data shows two cycles after the strobe ends.
    ext_data_t data_s1_q;
    ext_data_t data_s2_q;
    logic      cap0_q;
    logic      cap1_q;
    logic      last0_q;
    logic      last1_q;

    always_ff @(posedge core_clk_i)
    begin
        data_s1_q <= external_data_i;
        data_s2_q <= data_s1_q;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            cap0_q  <= 1'b0;
            cap1_q  <= 1'b0;
            last0_q <= 1'b0;
            last1_q <= 1'b0;
        end
        else
        begin
            cap0_q  <= leave_strobe;
            last0_q <= leave_strobe && (beats_left_q == '0);
            cap1_q  <= cap0_q;
            last1_q <= last0_q;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rd_data_o  <= `DATA_RESET;
            rd_valid_o <= 1'b0;
            rd_last_o  <= 1'b0;
        end
        else
        begin
            rd_valid_o <= cap1_q;
            rd_last_o  <= last1_q;
            if (cap1_q)
                rd_data_o <= data_s2_q;
        end
    end

    // =================================================================
    // Requester handshake
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            req_accept_o <= 1'b0;
            req_abort_o  <= 1'b0;
            done_o       <= 1'b0;
            busy_o       <= 1'b0;
        end
        else
        begin
            req_accept_o <= accept;
            req_abort_o  <= (state_q == ST_TURN) && cnt_zero && !top_priority_i;
            done_o       <= leave_final;
            busy_o       <= accept || ((state_q != ST_IDLE) &&
                            !leave_final && !((state_q == ST_TURN) && cnt_zero && !top_priority_i));
        end
    end

    // =================================================================
    // Checks
    logic [`CNT_W-1:0] phase_len_q;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || cnt_load)
            phase_len_q <= '0;
        else
            phase_len_q <= phase_len_q + `CNT_W'(1);
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_we_idle: assert property (##1 write_strobe_n_o) else $error("write strobe low during read");
    a_start_prio: assert property ($rose(req_accept_o) |-> $past(req_valid_i && top_priority_i))
        else $error("read started without priority");
    a_read_skip_turn: assert property (accept && last_op_q == LAST_READ |=> state_q == ST_SETUP)
        else $error("turnaround inserted after read");
    a_write_zero_turn: assert property (accept && last_op_q == LAST_WRITE && ta_field == '0
        |=> state_q == ST_TURN ##1 state_q == ST_SETUP || state_q == ST_IDLE)
        else $error("zero turnaround after write not one cycle");
    a_abort_no_setup: assert property (state_q == ST_TURN && cnt_zero && !top_priority_i
        |=> state_q == ST_IDLE && req_abort_o && output_enable_n_o)
        else $error("lost priority did not abandon read");
    a_ss_strobe_low: assert property (state_q == ST_STROBE && ss_q
        |-> !output_enable_n_o && !chip_select_n_o[region_q])
        else $error("select and enable not low in strobe");
    a_ss_strobe_end: assert property (leave_strobe && ss_q
        |=> output_enable_n_o && chip_select_n_o == '1)
        else $error("select or enable still low after strobe");
    a_strobe_length: assert property (leave_strobe |-> phase_len_q == `CNT_W'(strobe_q))
        else $error("strobe phase length wrong");
    a_hold_release: assert property (leave_final |=> byte_enable_n_o == `BE_IDLE
        && external_address_o == `ADDR_IDLE)
        else $error("address or byte enables not released");
    a_beat_keeps: assert property (enter_again |=> state_q == ST_SETUP && $stable(setup_q)
        && $stable(strobe_q) && $stable(hold_q))
        else $error("next beat changed timings");
    a_data_capture: assert property (cap0_q |-> ##2 rd_valid_o
        && rd_data_o == $past(external_data_i, 3))
        else $error("read data not the strobe-end sample");

    c_abort: cover property (req_abort_o);
    c_multi_beat: cover property (enter_again ##[1:200] done_o);
    c_skip_turn: cover property (accept && last_op_q == LAST_READ);
    c_normal_mode: cover property (state_q == ST_SETUP && !ss_q && chip_select_n_o != '1);

endmodule : async_read_select_strobe

// ### testbench/async_mem_model.sv
// Behavioural external asynchronous memory for the read sequencer bench.
// Assumes select-strobe reads: answers only while selected and enabled.
`timescale 1ns/1ps

module async_mem_model (
    input  wire logic [3:0]  chip_select_n_i,    // Region selects, low
    input  wire logic        output_enable_n_i,  // Output enable, low
    input  wire logic [12:0] external_address_i, // Memory address
    output logic [15:0]      external_data_o     // Memory data bus
);
    logic [15:0] last_q;

    // ==========================================================
    // Read data
    // Released bus shows the inverse, so a stale word never matches
    always @*
    begin
        if (!(&chip_select_n_i) && !output_enable_n_i)
        begin
            last_q          = {external_address_i, 3'h5};
            external_data_o = last_q;
        end
        else
            external_data_o = ~last_q;
    end
endmodule : async_mem_model

// ### testbench/test_async_read_select_strobe.sv
// Self-checking bench for the select-strobe read sequencer.
// Assumes the memory model on the far side; inputs driven on falling edges.
`timescale 1ns/1ps

module test_async_read_select_strobe;
    import async_read_pkg::*;
    typedef struct { int rg; int bt; int su; int sb; int hd; int ta; int et; bit wr; } row_t;
    logic            core_clk_i = 1'b0, rst_i = 1'b1, rv = 1'b0, top = 1'b0, wd = 1'b0;
    region_idx_t     rg = 2'h0;
    ext_addr_t       ra = 13'h0000, base = 13'h0000, ea;
    logic [1:0]      rb = 2'h0, rbe = 2'h3, ba, be_n;
    logic [2:0]      rbt = 3'h0;
    logic [3:0][1:0] ta = 8'h00;
    logic [3:0][3:0] su = 16'h0000;
    logic [3:0][5:0] sb = 24'h000000;
    logic [3:0][2:0] hd = 12'h000;
    logic [3:0]      cs_n;
    logic [3:0]      ss = 4'hF;
    ext_data_t       dq, rd;
    logic            oe_n, we_n, acc, ab, busy, rvld, rlast, done;
    int              n_mismatch = 0, cmp_count = 0, cyc = 0, nv = 0, t;
    row_t rows [4] = '{'{0, 0, 0, 1, 0, 3, 3, 0}, '{1, 2, 2, 0, 1, 3, 0, 0},
                       '{2, 1, 1, 3, 2, 0, 1, 1}, '{3, 7, 0, 0, 0, 2, 2, 1}};

    async_read_select_strobe dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .req_valid_i(rv),
        .req_region_i(rg), .req_addr_i(ra), .req_bank_i(rb), .req_byte_en_i(rbe), .req_beats_i(rbt),
        .top_priority_i(top), .write_done_i(wd), .cfg_ss_i(ss), .cfg_turn_i(ta), .cfg_setup_i(su),
        .cfg_strobe_i(sb), .cfg_hold_i(hd), .external_data_i(dq), .chip_select_n_o(cs_n),
        .output_enable_n_o(oe_n), .write_strobe_n_o(we_n), .external_address_o(ea), .bank_address_o(ba),
        .byte_enable_n_o(be_n), .req_accept_o(acc), .req_abort_o(ab), .busy_o(busy), .rd_data_o(rd),
        .rd_valid_o(rvld), .rd_last_o(rlast), .done_o(done));
    async_mem_model mem_u (.chip_select_n_i(cs_n), .output_enable_n_i(oe_n),
        .external_address_i(ea), .external_data_o(dq));

    initial forever #12.5 core_clk_i = ~core_clk_i;

    function automatic ext_data_t pat(input ext_addr_t a);
        return {a, 3'h5};
    endfunction : pat

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task final_report;
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report

    // ==========================================================
    // Watchdog and background monitors
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_mismatch++;
            final_report;
        end
    end
    always @(negedge core_clk_i)
    begin
        if (!rst_i) check("write_strobe", we_n, 1'b1);
        if (rvld)
        begin
            check("rd_data", rd, pat(base + 13'(nv)));
            check("rd_last", rlast, 16'(nv == rbt));
            nv++;
        end
    end

    // ==========================================================
    // One request, timed against the region's phase fields
    task automatic do_read(input row_t r);
        int s;
        rg = 2'(r.rg); rbt = 3'(r.bt); ta[rg] = 2'(r.ta); su[rg] = 4'(r.su); sb[rg] = 6'(r.sb);
        hd[rg] = 3'(r.hd); ra = {2'(r.rg), 11'h0F0}; rb = 2'(r.rg); rbe = 2'(r.rg) | 2'h1;
        base = ra; nv = 0;
        if (r.wr)
        begin
            wd = 1'b1;
            @(negedge core_clk_i) wd = 1'b0;
        end
        rv = 1'b1; top = 1'b1; t = 0;
        do begin @(negedge core_clk_i); t++; end while (!acc && t < 30);
        rv = 1'b0; t = 0;
        while (be_n === 2'h3 && t < 20) begin @(negedge core_clk_i); t++; end
        check("turnaround", 16'(t), 16'(r.et));
        check("bank", ba, rb);
        check("byte_enable", be_n, 2'(~rbe));
        check("busy", busy, 1'b1);
        for (int i = 0; i <= r.bt; i++)
        begin
            s = 0;
            while (cs_n[rg] && s < 80) begin @(negedge core_clk_i); s++; end
            check("setup_len", 16'(s), 16'((i == 0) ? r.su + 1 : r.hd + r.su + 2));
            check("oe_with_cs", oe_n, 1'b0);
            check("address", ea, ra + 13'(i));
            s = 0;
            while (!cs_n[rg] && s < 80) begin @(negedge core_clk_i); s++; end
            check("strobe_len", 16'(s), 16'(r.sb + 1));
            check("oe_rise", oe_n, 1'b1);
        end
        s = 0;
        while (be_n !== 2'h3 && s < 20) begin @(negedge core_clk_i); s++; end
        check("hold_len", 16'(s), 16'(r.hd + 1));
        check("addr_release", ea, 13'h0000);
        check("done", done, 1'b1);
        check("busy_end", busy, 1'b0);
        repeat (3) @(negedge core_clk_i);
        check("beats", 16'(nv), 16'(r.bt + 1));
    endtask : do_read

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (3) @(negedge core_clk_i);
        rst_i = 1'b0;
        @(negedge core_clk_i);
        check("reset_cs", cs_n, 4'hF);
        check("reset_be", be_n, 2'h3);
        check("reset_busy", busy, 1'b0);
        rv = 1'b1;
        repeat (5) @(negedge core_clk_i) check("refused", acc, 1'b0);
        rv = 1'b0;
        foreach (rows[k]) do_read(rows[k]);
        // Lost priority during turnaround: no chip select may move
        rg = 2'h0; ta[0] = 2'h2; wd = 1'b1;
        @(negedge core_clk_i) wd = 1'b0;
        rv = 1'b1; top = 1'b1; t = 0;
        do begin @(negedge core_clk_i); t++; end while (!acc && t < 30);
        rv = 1'b0; top = 1'b0; t = 0;
        while (!ab && t < 10) begin check("abort_cs", cs_n, 4'hF); @(negedge core_clk_i); t++; end
        check("abort", ab, 1'b1);
        do_read('{0, 0, 1, 2, 1, 2, 2, 0});
        // Normal mode on region 0: select spans setup to hold end
        ss = 4'hE; nv = 0; rv = 1'b1; t = 0;
        do begin @(negedge core_clk_i); t++; end while (!acc && t < 30);
        rv = 1'b0;
        check("normal_oe", oe_n, 1'b1);
        while (be_n !== 2'h3 && t < 60) begin check("normal_cs", cs_n, 4'hE); @(negedge core_clk_i); t++; end
        check("normal_end", cs_n, 4'hF);
        repeat (3) @(negedge core_clk_i);
        check("normal_beats", 16'(nv), 16'h0001);
        final_report;
    end
endmodule : test_async_read_select_strobe
